// >>> logic/psa_flow_core.sv
// program counter, return stack use, indirect addressing and register bus
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
module psa_flow_core #(
    parameter logic [psa_pkg::PC_W-1:0] IRQ_VECTOR = psa_pkg::IRQ_VECTOR_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inst_step,
    input wire logic inst_call,
    input wire logic inst_jump,
    input wire logic inst_return,
    input wire logic irq_take,
    input wire logic [psa_pkg::OPND_W-1:0] inst_operand,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic [psa_pkg::FILE_W-1:0] file_addr,
    input wire logic [psa_pkg::DATA_W-1:0] file_wdata,
    output logic [psa_pkg::DATA_W-1:0] file_rdata,
    output logic file_rdata_valid,
    output logic [psa_pkg::PC_W-1:0] pc_out,
    output logic [psa_pkg::DADDR_W-1:0] dmem_addr,
    output logic dmem_we,
    output logic dmem_re,
    output logic [psa_pkg::DATA_W-1:0] dmem_wdata,
    input wire logic [psa_pkg::DATA_W-1:0] dmem_rdata,
    input wire logic [psa_pkg::BUS_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [psa_pkg::BUS_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////////
    logic [psa_pkg::PC_W-1:0] pc_reg, pc_next;
    logic [psa_pkg::HOLD_W-1:0] hold_reg, hold_next;
    logic [psa_pkg::DATA_W-1:0] ptr_reg, ptr_next;
    logic ibank_reg, ibank_next;
    logic [1:0] rp_reg, rp_next;

    logic stk_push, stk_pop;
    logic [psa_pkg::PC_W-1:0] stk_push_data, stk_top;

    // file access decode
    logic acc_ind, acc_self, acc_core;
    logic [psa_pkg::DADDR_W-1:0] acc_addr;
    logic [psa_pkg::DATA_W-1:0] core_rd_val;
    logic fw_pcl, fw_ptr, fw_status, fw_hold;

    // bus write commit
    logic bus_commit, bus_pcl, bus_ptr, bus_hold, bus_bank;
    logic core_busy;

    assign pc_out = pc_reg;
    assign core_busy = inst_step | inst_call | inst_jump | inst_return | irq_take |
                       file_rd | file_wr;

    always_comb begin
        acc_ind = file_addr == psa_pkg::F_INDIRECT_OPERAND;
        if (acc_ind) begin
            acc_addr = {ibank_reg, ptr_reg};
        end else begin
            acc_addr = {rp_reg, file_addr};
        end
        acc_self = acc_ind && acc_addr[psa_pkg::FILE_W-1:0] == psa_pkg::F_INDIRECT_OPERAND;
        case (acc_addr[psa_pkg::FILE_W-1:0])
            psa_pkg::F_PROGRAM_COUNTER_LOW: begin
                acc_core = 1'b1;
                core_rd_val = pc_reg[psa_pkg::PCL_W-1:0];
            end
            psa_pkg::F_INDIRECT_POINTER: begin
                acc_core = 1'b1;
                core_rd_val = ptr_reg;
            end
            psa_pkg::F_STATUS: begin
                acc_core = 1'b1;
                core_rd_val = {ibank_reg, rp_reg, 5'h00};
            end
            psa_pkg::F_UPPER_ADDRESS_HOLDING: begin
                acc_core = 1'b1;
                core_rd_val = {3'h0, hold_reg};
            end
            default: begin
                acc_core = 1'b0;
                core_rd_val = 8'h00;
            end
        endcase
        if (acc_self) begin
            acc_core = 1'b0;
            core_rd_val = 8'h00;
        end
        fw_pcl = file_wr && acc_core &&
                 acc_addr[psa_pkg::FILE_W-1:0] == psa_pkg::F_PROGRAM_COUNTER_LOW;
        fw_ptr = file_wr && acc_core &&
                 acc_addr[psa_pkg::FILE_W-1:0] == psa_pkg::F_INDIRECT_POINTER;
        fw_status = file_wr && acc_core && acc_addr[psa_pkg::FILE_W-1:0] == psa_pkg::F_STATUS;
        fw_hold = file_wr && acc_core &&
                  acc_addr[psa_pkg::FILE_W-1:0] == psa_pkg::F_UPPER_ADDRESS_HOLDING;
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter and core registers; returns outrank branches, branches a write
    always_comb begin
        pc_next = pc_reg;
        hold_next = hold_reg;
        ptr_next = ptr_reg;
        ibank_next = ibank_reg;
        rp_next = rp_reg;
        stk_push = 1'b0;
        stk_pop = 1'b0;
        stk_push_data = pc_reg;
        if (inst_return) begin
            stk_pop = 1'b1;
            pc_next = stk_top;
        end else if (inst_call || inst_jump) begin
            stk_push = inst_call;
            stk_push_data = pc_reg + psa_pkg::PC_ONE;
            pc_next = {hold_reg[psa_pkg::HOLD_PAGE_HI:psa_pkg::HOLD_PAGE_LO],
                       inst_operand};
        end else if (irq_take) begin
            stk_push = 1'b1;
            pc_next = IRQ_VECTOR;
        end else if (fw_pcl) begin
            pc_next = {hold_reg, file_wdata};
        end else if (bus_pcl) begin
            pc_next = {hold_reg, s_axi_wdata[psa_pkg::PCL_W-1:0]};
        end else if (inst_step) begin
            pc_next = pc_reg + psa_pkg::PC_ONE;
        end
        // holding register changes only through explicit writes
        if (fw_hold) begin
            hold_next = file_wdata[psa_pkg::HOLD_W-1:0];
        end else if (bus_hold) begin
            hold_next = s_axi_wdata[psa_pkg::HOLD_W-1:0];
        end
        if (fw_ptr) begin
            ptr_next = file_wdata;
        end else if (bus_ptr) begin
            ptr_next = s_axi_wdata[psa_pkg::DATA_W-1:0];
        end
        if (fw_status) begin
            ibank_next = file_wdata[psa_pkg::ST_INDIRECT_BANK];
            rp_next = file_wdata[psa_pkg::ST_BANK_HI:psa_pkg::ST_BANK_LO];
        end else if (bus_bank) begin
            ibank_next = s_axi_wdata[psa_pkg::ST_INDIRECT_BANK];
            rp_next = s_axi_wdata[psa_pkg::ST_BANK_HI:psa_pkg::ST_BANK_LO];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_reg <= psa_pkg::PC_RESET;
            hold_reg <= '0;
            ptr_reg <= '0;
            ibank_reg <= 1'b0;
            rp_reg <= 2'h0;
        end else begin
            pc_reg <= pc_next;
            hold_reg <= hold_next;
            ptr_reg <= ptr_next;
            ibank_reg <= ibank_next;
            rp_reg <= rp_next;
        end
    end

    // hidden from software: no bus path reaches the pointer or entries
    psa_return_stack #(
        .DEPTH(psa_pkg::STACK_DEPTH),
        .WIDTH(psa_pkg::PC_W)
    ) u_stack (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(stk_push_data),
        .top_data(stk_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    // data-memory stage; memory read is combinational on dmem_addr
    logic [psa_pkg::DADDR_W-1:0] dmem_addr_next;
    logic dmem_we_next, dmem_re_next;
    logic [psa_pkg::DATA_W-1:0] dmem_wdata_next;
    logic rd_core_reg, rd_core_next;
    logic [psa_pkg::DATA_W-1:0] rd_val_reg, rd_val_next;
    logic [psa_pkg::DATA_W-1:0] file_rdata_next;
    logic file_rdata_valid_next;

    always_comb begin
        dmem_addr_next = dmem_addr;
        dmem_wdata_next = dmem_wdata;
        dmem_we_next = 1'b0;
        dmem_re_next = 1'b0;
        rd_core_next = 1'b0;
        rd_val_next = core_rd_val;
        if (file_wr && !acc_core && !acc_self) begin
            dmem_we_next = 1'b1;
            dmem_addr_next = acc_addr;
            dmem_wdata_next = file_wdata;
        end else if (file_rd) begin
            rd_core_next = acc_core || acc_self;
            dmem_re_next = !(acc_core || acc_self);
            if (!(acc_core || acc_self)) begin
                dmem_addr_next = acc_addr;
            end
        end
        file_rdata_valid_next = dmem_re || rd_core_reg;
        file_rdata_next = file_rdata;
        if (rd_core_reg) begin
            file_rdata_next = rd_val_reg;
        end else if (dmem_re) begin
            file_rdata_next = dmem_rdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dmem_addr <= '0;
            dmem_we <= 1'b0;
            dmem_re <= 1'b0;
            dmem_wdata <= '0;
            rd_core_reg <= 1'b0;
            rd_val_reg <= '0;
            file_rdata <= '0;
            file_rdata_valid <= 1'b0;
        end else begin
            dmem_addr <= dmem_addr_next;
            dmem_we <= dmem_we_next;
            dmem_re <= dmem_re_next;
            dmem_wdata <= dmem_wdata_next;
            rd_core_reg <= rd_core_next;
            rd_val_reg <= rd_val_next;
            file_rdata <= file_rdata_next;
            file_rdata_valid <= file_rdata_valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus; a write waits while the core is busy so it never races
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [psa_pkg::BUS_AW-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic wstrb0_reg, wstrb0_next;
    logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
    logic [1:0] bresp_next, rresp_next;
    logic [31:0] rdata_next;
    logic bus_known;

    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = s_axi_bvalid && !s_axi_bready;
        bresp_next = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb0_next = s_axi_wstrb[0];
        end
        bus_commit = aw_got_reg && w_got_reg && !s_axi_bvalid && !core_busy;
        bus_known = awaddr_reg == psa_pkg::A_PROGRAM_COUNTER_LOW ||
                    awaddr_reg == psa_pkg::A_INDIRECT_POINTER ||
                    awaddr_reg == psa_pkg::A_UPPER_ADDRESS_HOLDING ||
                    awaddr_reg == psa_pkg::A_BANK_SELECT;
        bus_pcl = bus_commit && wstrb0_reg && awaddr_reg == psa_pkg::A_PROGRAM_COUNTER_LOW;
        bus_ptr = bus_commit && wstrb0_reg && awaddr_reg == psa_pkg::A_INDIRECT_POINTER;
        bus_hold = bus_commit && wstrb0_reg && awaddr_reg == psa_pkg::A_UPPER_ADDRESS_HOLDING;
        bus_bank = bus_commit && wstrb0_reg && awaddr_reg == psa_pkg::A_BANK_SELECT;
        if (bus_commit) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = bus_known ? psa_pkg::RESP_OKAY : psa_pkg::RESP_SLVERR;
        end
        awready_next = !aw_got_next;
        wready_next = !w_got_next;
        // read side: one answer at a time, ready only while nothing is owed
        rvalid_next = s_axi_rvalid && !s_axi_rready;
        rdata_next = s_axi_rdata;
        rresp_next = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = psa_pkg::RESP_OKAY;
            case (s_axi_araddr)
                psa_pkg::A_PROGRAM_COUNTER_LOW: begin
                    rdata_next = {24'h000000, pc_reg[psa_pkg::PCL_W-1:0]};
                end
                psa_pkg::A_INDIRECT_POINTER: begin
                    rdata_next = {24'h000000, ptr_reg};
                end
                psa_pkg::A_UPPER_ADDRESS_HOLDING: begin
                    rdata_next = {27'h0000000, hold_reg};
                end
                psa_pkg::A_BANK_SELECT: begin
                    rdata_next = {24'h000000, ibank_reg, rp_reg, 5'h00};
                end
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = psa_pkg::RESP_SLVERR;
                end
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= psa_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= psa_pkg::RESP_OKAY;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            s_axi_awready <= awready_next;
            s_axi_wready <= wready_next;
            s_axi_bvalid <= bvalid_next;
            s_axi_bresp <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid <= rvalid_next;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_call_then_ret;
        inst_call && !inst_return ##1 inst_return;
    endsequence

    a_reset_clears_pc: assert property (@(posedge clk) sys_rst |-> pc_reg == '0)
        else $error("counter not cleared in reset");
    a_pcl_write_load: assert property (@(posedge clk) disable iff (sys_rst)
        fw_pcl && !inst_return && !inst_call && !inst_jump && !irq_take
        |=> pc_reg == {$past(hold_reg), $past(file_wdata)})
        else $error("low byte write loaded wrong counter");
    a_branch_load: assert property (@(posedge clk) disable iff (sys_rst)
        (inst_call || inst_jump) && !inst_return
        |=> pc_reg == {$past(hold_reg[psa_pkg::HOLD_PAGE_HI:psa_pkg::HOLD_PAGE_LO]),
                       $past(inst_operand)})
        else $error("branch target wrong");
    a_call_return: assert property (@(posedge clk) disable iff (sys_rst)
        s_call_then_ret |=> pc_reg == $past(pc_reg, 2) + psa_pkg::PC_ONE)
        else $error("return did not restore call site");
    a_irq_push: assert property (@(posedge clk) disable iff (sys_rst)
        irq_take && !inst_return && !inst_call && !inst_jump ##1 inst_return
        |=> pc_reg == $past(pc_reg, 2))
        else $error("interrupt return address wrong");
    a_hold_kept: assert property (@(posedge clk) disable iff (sys_rst)
        (stk_push || stk_pop) && !fw_hold && !bus_hold |=> $stable(hold_reg))
        else $error("holding register moved on stack use");
    a_self_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
        file_rd && !file_wr && acc_self
        |=> !dmem_re ##1 file_rdata_valid && file_rdata == 8'h00)
        else $error("self-pointed read not zero");
    a_self_write_none: assert property (@(posedge clk) disable iff (sys_rst)
        file_wr && acc_self |=> !dmem_we && $stable(ptr_reg))
        else $error("self-pointed write stored data");
    a_indirect_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (file_rd || file_wr) && acc_ind && !acc_self && !acc_core
        |=> dmem_addr == {$past(ibank_reg), $past(ptr_reg)})
        else $error("indirect address wrong");
    a_direct_bank: assert property (@(posedge clk) disable iff (sys_rst)
        (file_rd || file_wr) && !acc_ind && !acc_core
        |=> dmem_addr == {$past(rp_reg), $past(file_addr)})
        else $error("direct bank address wrong");
endmodule
`default_nettype wire

// >>> logic/psa_pkg.sv
// shared constants for the program-flow and indirect-addressing block
package psa_pkg;
    localparam int PC_W = 13;
    localparam int PCL_W = 8;
    localparam int HOLD_W = 5;
    localparam int OPND_W = 11;
    localparam int FILE_W = 7;
    localparam int DADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 8;

    // core-register offsets inside each data bank, mirrored in every bank
    localparam logic [6:0] F_INDIRECT_OPERAND = 7'h00;
    localparam logic [6:0] F_PROGRAM_COUNTER_LOW = 7'h01;
    localparam logic [6:0] F_INDIRECT_POINTER = 7'h02;
    localparam logic [6:0] F_STATUS = 7'h03;
    localparam logic [6:0] F_UPPER_ADDRESS_HOLDING = 7'h04;

    // status bit positions held here
    localparam int ST_INDIRECT_BANK = 7;
    localparam int ST_BANK_HI = 6;
    localparam int ST_BANK_LO = 5;

    // holding bits copied on a branch
    localparam int HOLD_PAGE_HI = 4;
    localparam int HOLD_PAGE_LO = 3;

    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] IRQ_VECTOR_DEFAULT = 13'h0004;

    // bus map, byte addresses
    localparam logic [7:0] A_PROGRAM_COUNTER_LOW = 8'h00;
    localparam logic [7:0] A_INDIRECT_POINTER = 8'h04;
    localparam logic [7:0] A_UPPER_ADDRESS_HOLDING = 8'h08;
    localparam logic [7:0] A_BANK_SELECT = 8'h0c;
    localparam int BUS_AW = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> logic/psa_return_stack.sv
// circular return stack of program-counter values
`timescale 1ns/10ps
`default_nettype none
module psa_return_stack #(
    parameter int DEPTH = psa_pkg::STACK_DEPTH,
    parameter int WIDTH = psa_pkg::PC_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] ptr_next;
    logic [WIDTH-1:0] entry_reg [DEPTH];

    // pointer wraps both ways with no flag: overflow and underflow are silent
    always_comb begin
        ptr_next = ptr_reg;
        if (push) begin
            ptr_next = ptr_reg + PTR_ONE;
        end else if (pop) begin
            ptr_next = ptr_reg - PTR_ONE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr_reg <= '0;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            logic [WIDTH-1:0] entry_next;
            always_comb begin
                entry_next = entry_reg[gi];
                if (push && ptr_reg == PTR_W'(gi)) begin
                    entry_next = push_data;
                end
            end
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    entry_reg[gi] <= '0;
                end else begin
                    entry_reg[gi] <= entry_next;
                end
            end
        end
    endgenerate

    assign top_data = entry_reg[ptr_reg - PTR_ONE];

    a_ptr_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        push |=> ptr_reg == $past(ptr_reg) + PTR_ONE && entry_reg[$past(ptr_reg)] == $past(push_data))
        else $error("stack push did not wrap or store");
endmodule
`default_nettype wire

// >>> tb/psa_dmem_model.sv
// data memory beside the block: combinational read, scrambled when idle
`timescale 1ns/10ps
`default_nettype none
module psa_dmem_model (
    input wire logic clk,
    input wire logic re,
    input wire logic [8:0] addr,
    output logic [7:0] rdata
);
    logic [7:0] idle_reg = 8'h00;
    // idle bus moves every cycle so a late sample cannot match by luck
    always @(posedge clk) begin
        idle_reg <= idle_reg + 8'h3b;
    end
    // content is a fixed function of the address, so no storage needed
    assign rdata = re ? (~addr[7:0] ^ {addr[8], 7'h00}) : idle_reg;
endmodule
`default_nettype wire

// >>> tb/tb_psa_flow_core.sv
// self-checking bench for the program-flow and indirect-addressing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_psa_flow_core;
    logic clk = 1'b0, sys_rst = 1'b0, file_rd = 1'b0, file_wr = 1'b0;
    logic [3:0] ws = 4'hf;
    logic [4:0] k = 5'h00;
    logic [10:0] opd = 11'h000;
    logic [6:0] fad = 7'h00;
    logic [7:0] fwd = 8'h00, frd, dwd, mrd, aa = 8'h00, ara = 8'h00;
    logic frv, dwe, dre, awr, wr, bv, arr, rv;
    logic [12:0] pc;
    logic [8:0] dad;
    logic [31:0] awd = 32'h0, rd, rsv;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [1:0] bres, rres, rrs, brs;
    int n_errors = 0, num_checks = 0;
    psa_flow_core psa_flow_core_inst (.clk(clk), .sys_rst(sys_rst), .inst_step(k[4]),
        .inst_call(k[3]), .inst_jump(k[2]), .inst_return(k[1]), .irq_take(k[0]),
        .inst_operand(opd), .file_rd(file_rd), .file_wr(file_wr), .file_addr(fad),
        .file_wdata(fwd), .file_rdata(frd), .file_rdata_valid(frv), .pc_out(pc),
        .dmem_addr(dad), .dmem_we(dwe), .dmem_re(dre), .dmem_wdata(dwd), .dmem_rdata(mrd),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(awd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rres), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    psa_dmem_model psa_dmem_model_inst (.clk(clk), .re(dre), .addr(dad), .rdata(mrd));
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // kinds: 08 call, 04 jump, 02 return, 01 interrupt
    task op(input logic [4:0] kk, input logic [10:0] o);
        @(posedge clk);
        k <= kk;
        opd <= o;
        @(posedge clk);
        k <= 5'h00;
        #1;
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aa <= a;
        awd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        brs = bres;
        br <= 1'b0;
        #1;
    endtask
    task axr(input logic [7:0] a);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rsv = rd;
        rrs = rres;
        rr <= 1'b0;
    endtask
    // after return the strobes of the take edge are visible
    task fa(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        file_rd <= r;
        file_wr <= w;
        fad <= a;
        fwd <= d;
        @(posedge clk);
        file_rd <= 1'b0;
        file_wr <= 1'b0;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_pcl;
        axw(psa_pkg::A_UPPER_ADDRESS_HOLDING, 32'h1f);
        axw(psa_pkg::A_PROGRAM_COUNTER_LOW, 32'h5a);
        `CHK(pc, 13'h1f5a)
        `CHK(brs, psa_pkg::RESP_OKAY)
        axw(8'h40, 32'h1234);
        `CHK(brs, psa_pkg::RESP_SLVERR)
        // low strobe clear: answered, but the counter must not move
        ws <= 4'he;
        axw(psa_pkg::A_PROGRAM_COUNTER_LOW, 32'h11);
        `CHK(brs, psa_pkg::RESP_OKAY)
        `CHK(pc, 13'h1f5a)
        ws <= 4'hf;
        fa(1'b0, 1'b1, psa_pkg::F_PROGRAM_COUNTER_LOW, 8'h33);
        `CHK(dwe, 1'b0)
        `CHK(pc, 13'h1f33)
        axr(psa_pkg::A_PROGRAM_COUNTER_LOW);
        `CHK(rsv, 32'h33)
        axr(8'h40);
        `CHK(rrs, psa_pkg::RESP_SLVERR)
    endtask
    task t_jump;
        op(5'h04, 11'h123);
        `CHK(pc, 13'h1923)
        axw(psa_pkg::A_UPPER_ADDRESS_HOLDING, 32'h07);
        op(5'h04, 11'h7ff);
        `CHK(pc, 13'h07ff)
        op(5'h10, 11'h000);
        `CHK(pc, 13'h0800)
    endtask
    // call then return, interrupt then return, each on consecutive edges
    task t_b2b;
        @(posedge clk);
        k <= 5'h08;
        opd <= 11'h200;
        @(posedge clk);
        k <= 5'h02;
        @(posedge clk);
        k <= 5'h01;
        #1;
        `CHK(pc, 13'h0082)
        @(posedge clk);
        k <= 5'h02;
        #1;
        `CHK(pc, 13'h0004)
        @(posedge clk);
        k <= 5'h00;
        #1;
        `CHK(pc, 13'h0082)
    endtask
    // nine calls: the ninth overwrites the first, pops wrap silently
    task t_stack;
        op(5'h04, 11'h000);
        for (int i = 1; i <= 9; i++) op(5'h08, 11'(i * 16));
        for (int i = 9; i >= 2; i--) begin
            op(5'h02, 11'h000);
            `CHK(pc, 13'((i - 1) * 16 + 1))
        end
        op(5'h02, 11'h000);
        `CHK(pc, 13'h0081)
        op(5'h01, 11'h000);
        `CHK(pc, 13'h0004)
        op(5'h02, 11'h000);
        `CHK(pc, 13'h0081)
        axr(psa_pkg::A_UPPER_ADDRESS_HOLDING);
        `CHK(rsv, 32'h07)
    endtask
    task t_ind;
        fa(1'b0, 1'b1, psa_pkg::F_INDIRECT_POINTER, 8'h20);
        fa(1'b0, 1'b1, psa_pkg::F_STATUS, 8'h80);
        fa(1'b0, 1'b1, psa_pkg::F_INDIRECT_OPERAND, 8'ha5);
        `CHK({dwe, dad, dwd}, {1'b1, 9'h120, 8'ha5})
        fa(1'b1, 1'b0, psa_pkg::F_INDIRECT_OPERAND, 8'h00);
        @(posedge clk);
        #1;
        `CHK({frv, frd}, {1'b1, 8'h5f})
        fa(1'b0, 1'b1, psa_pkg::F_INDIRECT_POINTER, 8'h00);
        fa(1'b1, 1'b0, psa_pkg::F_INDIRECT_OPERAND, 8'h00);
        @(posedge clk);
        #1;
        `CHK({frv, frd}, {1'b1, 8'h00})
        fa(1'b0, 1'b1, psa_pkg::F_INDIRECT_OPERAND, 8'h77);
        `CHK(dwe, 1'b0)
        fa(1'b0, 1'b1, psa_pkg::F_STATUS, 8'h60);
        fa(1'b1, 1'b0, 7'h10, 8'h00);
        `CHK({dre, dad}, {1'b1, 9'h190})
        @(posedge clk);
        #1;
        `CHK(frd, 8'hef)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        // rising reset edge at time zero, so the counter is never unknown
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(pc, 13'h0000)
        t_pcl();
        t_jump();
        t_stack();
        t_b2b();
        t_ind();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        `CHK(pc, 13'h0000)
        stop_test();
    end
endmodule
`default_nettype wire
